/* rtl/pvc_consts.svh */
// Constants for the personal code verify, change and disable handler
// Operation
// - Compare on verify only if enabled, unblocked.
// - Protected function needs verification unless code disabled.
// - Correct verify reloads retry counter to 3.
// - Wrong code decrements counter; first answers 63C2.
// - Second consecutive wrong attempt answers 63C1.
// - Third wrong attempt blocks, answers 63C0.
// - Verify with data on blocked code: 6983.
// - Blocked code keeps access unsatisfied until unblock.
// - Empty verify returns remaining retries as 63CX.
// - Empty verify on blocked code: 63C0 or 6983.
// - Qualifier: b8 global/specific, b7-b6 zero, key 01-1F; code accepts key 01 to NK only.
// - Change only if enabled, unblocked, both codes given.
// - Correct old code reloads 3, stores new code.
// - Wrong old code decrements, keeps value, blocks third.
// - Disable refused when already disabled or blocked.
// - Correct disable reloads 3, marks code disabled.
// - Wrong disable decrements, stays enabled, blocks third.
// - Disabled code makes guarded files freely accessible.
// - Disable parameter picks alternative key, qualifier 08.
// - Single-reference files need the alternative key instead.
// - Unblock sets new code, reloads 3, enables.
`ifndef PVC_CONSTS_SVH
`define PVC_CONSTS_SVH
`define PVC_TRIES_INIT   2'h3
`define PVC_LEN_CODE     8'h08
`define PVC_LEN_CHANGE   8'h10
`define PVC_QUAL_USE     8'h08
`define PVC_QUAL_RESET   8'h00
`define PVC_REF_SPEC_BIT 7
`define PVC_ALT_BIT      7
`define PVC_SW_OK        16'h9000
`define PVC_SW_RETRY     12'h63C
`define PVC_SW_BLOCKED   16'h6983
`define PVC_SW_DISABLED  16'h6984
`define PVC_SW_BAD_LEN   16'h6700
`define PVC_SW_BAD_P1P2  16'h6B00
`define PVC_SW_NO_REF    16'h6A88
`endif

/* rtl/pvc_pkg.sv */
// Types shared by the code handler
`default_nettype none
package pvc_pkg;
  typedef enum logic [1:0] {
    PVC_OP_VERIFY  = 2'b00,
    PVC_OP_CHANGE  = 2'b01,
    PVC_OP_DISABLE = 2'b10,
    PVC_OP_UNBLOCK = 2'b11
  } pvc_op_type;
endpackage : pvc_pkg
`default_nettype wire

/* rtl/pvc_core.sv */
// Command handler for personal code verify, change, disable and unblock
`timescale 1ns/1ps
`default_nettype none
`include "pvc_consts.svh"
module pvc_core
  import pvc_pkg::*;
#(
  parameter int          NK        = 4,
  parameter logic [63:0] INIT_CODE = 64'hFFFF_FFFF_3433_3231
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_session_start,
  input  wire logic             i_cmd_valid,
  input  wire pvc_op_type       i_cmd_op,
  input  wire logic [7:0]       i_cmd_p1,
  input  wire logic [7:0]       i_cmd_p2,
  input  wire logic [7:0]       i_cmd_len,
  input  wire logic [63:0]      i_old_code,
  input  wire logic [63:0]      i_new_code,
  output var  logic             o_rsp_valid,
  output var  logic [15:0]      o_sw,
  output var  logic [2*NK-1:0]  o_access_ok
);
  localparam int KW = $clog2(NK);
  localparam int NS = 2 * NK;
  localparam int SW = KW + 1;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Slot index is the key number minus one, so NK must be a power of two
  if (NK < 2 || NK > 16 || (1 << KW) != NK) begin : g_bad_nk
    $error("pvc_core: NK must be a power of two from 2 to 16");
  end

  // ----------------------------------------------------------------
  // Reference decode
  // ----------------------------------------------------------------
  function automatic logic ref_ok(input logic [7:0] q);
    ref_ok = (q[6:5] == 2'b00) && (q[4:0] != 5'h00)
          && ({3'b000, q[4:0]} <= 8'(NK));
  endfunction : ref_ok

  function automatic logic [SW-1:0] slot_of(input logic [7:0] q);
    logic [4:0] k;
    k = q[4:0] - 5'h01;
    slot_of = {q[`PVC_REF_SPEC_BIT], k[KW-1:0]};
  endfunction : slot_of

  // ----------------------------------------------------------------
  // Code state
  // ----------------------------------------------------------------
  // Counters and flags survive sessions; only verified flags are per session
  logic [63:0]   code         [NS];
  logic [1:0]    tries        [NS];
  logic [7:0]    qual         [NS];
  logic [SW-1:0] alt_idx      [NS];
  logic [NS-1:0] dis;
  logic [NS-1:0] blk;
  logic [NS-1:0] ver;
  logic [NS-1:0] alt_on;
  logic [63:0]   next_code    [NS];
  logic [1:0]    next_tries   [NS];
  logic [7:0]    next_qual    [NS];
  logic [SW-1:0] next_alt_idx [NS];
  logic [NS-1:0] next_dis;
  logic [NS-1:0] next_blk;
  logic [NS-1:0] next_ver;
  logic [NS-1:0] next_alt_on;
  logic [NS-1:0] next_access;
  logic [15:0]   next_sw;
  logic [SW-1:0] sl;
  logic [SW-1:0] asl;
  logic          match;
  logic [1:0]    t;

  always_comb begin
    next_code    = code;
    next_tries   = tries;
    next_qual    = qual;
    next_alt_idx = alt_idx;
    next_dis     = dis;
    next_blk     = blk;
    next_ver     = i_session_start ? '0 : ver;
    next_alt_on  = alt_on;
    next_sw      = `PVC_SW_OK;
    sl           = slot_of(i_cmd_p2);
    asl          = slot_of({1'b0, i_cmd_p1[6:0]});
    match        = (i_old_code == code[sl]);
    t            = tries[sl] - 2'h1;
    if (i_cmd_valid) begin
      if (!ref_ok(i_cmd_p2)) begin
        next_sw = `PVC_SW_NO_REF;
      end else begin
        case (i_cmd_op)
          PVC_OP_VERIFY: begin
            if (i_cmd_p1 != 8'h00) begin
              next_sw = `PVC_SW_BAD_P1P2;
            end else if (i_cmd_len == 8'h00) begin
              // Blocked code has a zero counter, so this reads 63C0
              next_sw = {`PVC_SW_RETRY, 2'b00, tries[sl]};
            end else if (i_cmd_len != `PVC_LEN_CODE) begin
              next_sw = `PVC_SW_BAD_LEN;
            end else if (blk[sl]) begin
              next_sw = `PVC_SW_BLOCKED;
            end else if (dis[sl]) begin
              next_sw = `PVC_SW_DISABLED;
            end else if (match) begin
              next_tries[sl] = `PVC_TRIES_INIT;
              next_ver[sl]   = 1'b1;
            end else begin
              next_tries[sl] = t;
              next_ver[sl]   = 1'b0;
              next_blk[sl]   = (t == 2'h0);
              next_sw        = {`PVC_SW_RETRY, 2'b00, t};
            end
          end
          PVC_OP_CHANGE: begin
            if (i_cmd_p1 != 8'h00) begin
              next_sw = `PVC_SW_BAD_P1P2;
            end else if (i_cmd_len != `PVC_LEN_CHANGE) begin
              next_sw = `PVC_SW_BAD_LEN;
            end else if (blk[sl]) begin
              next_sw = `PVC_SW_BLOCKED;
            end else if (dis[sl]) begin
              next_sw = `PVC_SW_DISABLED;
            end else if (match) begin
              next_tries[sl] = `PVC_TRIES_INIT;
              next_code[sl]  = i_new_code;
            end else begin
              next_tries[sl] = t;
              next_ver[sl]   = 1'b0;
              next_blk[sl]   = (t == 2'h0);
              next_sw        = {`PVC_SW_RETRY, 2'b00, t};
            end
          end
          PVC_OP_DISABLE: begin
            if (i_cmd_p1[`PVC_ALT_BIT] ? !ref_ok({1'b0, i_cmd_p1[6:0]})
                                       : (i_cmd_p1 != 8'h00)) begin
              next_sw = `PVC_SW_BAD_P1P2;
            end else if (i_cmd_len != `PVC_LEN_CODE) begin
              next_sw = `PVC_SW_BAD_LEN;
            end else if (blk[sl]) begin
              next_sw = `PVC_SW_BLOCKED;
            end else if (dis[sl]) begin
              next_sw = `PVC_SW_DISABLED;
            end else if (match) begin
              next_tries[sl] = `PVC_TRIES_INIT;
              next_dis[sl]   = 1'b1;
              next_alt_on[sl] = i_cmd_p1[`PVC_ALT_BIT];
              next_alt_idx[sl] = asl;
              if (i_cmd_p1[`PVC_ALT_BIT]) begin
                next_qual[asl] = `PVC_QUAL_USE;
              end
            end else begin
              next_tries[sl] = t;
              next_ver[sl]   = 1'b0;
              next_blk[sl]   = (t == 2'h0);
              next_sw        = {`PVC_SW_RETRY, 2'b00, t};
            end
          end
          PVC_OP_UNBLOCK: begin
            // Unblock code itself is checked upstream; this is its success
            next_code[sl]   = i_new_code;
            next_tries[sl]  = `PVC_TRIES_INIT;
            next_blk[sl]    = 1'b0;
            next_dis[sl]    = 1'b0;
            next_alt_on[sl] = 1'b0;
            next_ver[sl]    = 1'b1;
          end
          default: next_sw = `PVC_SW_BAD_P1P2;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Access conditions
  // ----------------------------------------------------------------
  // Taken from the current state, so a grant lags its cause by one cycle
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      next_access[i] = (ver[i] & ~blk[i] & ~dis[i])
                     | (dis[i] & ~alt_on[i])
                     | (dis[i] & alt_on[i] & ver[alt_idx[i]]
                        & ~blk[alt_idx[i]]);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < NS; i++) begin
        code[i]    <= INIT_CODE;
        tries[i]   <= `PVC_TRIES_INIT;
        qual[i]    <= `PVC_QUAL_RESET;
        alt_idx[i] <= '0;
      end
      dis         <= '0;
      blk         <= '0;
      ver         <= '0;
      alt_on      <= '0;
      o_rsp_valid <= 1'b0;
      o_sw        <= `PVC_SW_OK;
      o_access_ok <= '0;
    end else begin
      code        <= next_code;
      tries       <= next_tries;
      qual        <= next_qual;
      alt_idx     <= next_alt_idx;
      dis         <= next_dis;
      blk         <= next_blk;
      ver         <= next_ver;
      alt_on      <= next_alt_on;
      o_rsp_valid <= i_cmd_valid;
      o_sw        <= next_sw;
      o_access_ok <= next_access;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Snapshot of the command that the current response answers
  logic          p_ok;
  pvc_op_type    p_op;
  logic [7:0]    p_p1;
  logic [7:0]    p_len;
  logic [SW-1:0] p_sl;
  logic [SW-1:0] p_asl;
  logic [1:0]    p_tries;
  logic          p_blk;
  logic          p_dis;
  logic          p_match;
  logic [63:0]   p_new;
  logic          p_good;

  always_ff @(posedge i_sys_clk) begin
    p_ok    <= ref_ok(i_cmd_p2);
    p_op    <= i_cmd_op;
    p_p1    <= i_cmd_p1;
    p_len   <= i_cmd_len;
    p_sl    <= sl;
    p_asl   <= asl;
    p_tries <= tries[sl];
    p_blk   <= blk[sl];
    p_dis   <= dis[sl];
    p_match <= match;
    p_new   <= i_new_code;
  end

  assign p_good = o_rsp_valid && p_ok && p_p1 == 8'h00 && !p_blk && !p_dis;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_verify_gate: assert property (o_rsp_valid && p_ok && p_op == PVC_OP_VERIFY
      && p_len == `PVC_LEN_CODE && (p_blk || p_dis) |-> o_sw != `PVC_SW_OK
      && tries[p_sl] == p_tries)
    else $error("verify compared a disabled or blocked code");
  a_verify_reload: assert property (p_good && p_op == PVC_OP_VERIFY
      && p_len == `PVC_LEN_CODE && p_match |-> tries[p_sl] == 2'h3 && o_sw == `PVC_SW_OK)
    else $error("correct verify did not reload counter");
  a_first_wrong: assert property (p_good && p_op == PVC_OP_VERIFY
      && p_len == `PVC_LEN_CODE && !p_match && p_tries == 2'h3 |-> o_sw == 16'h63C2)
    else $error("first wrong verify not 63C2");
  a_second_wrong: assert property (p_good && p_op == PVC_OP_VERIFY
      && p_len == `PVC_LEN_CODE && !p_match && p_tries == 2'h2 |-> o_sw == 16'h63C1)
    else $error("second wrong verify not 63C1");
  a_third_block: assert property (p_good && p_len == `PVC_LEN_CODE
      && p_op == PVC_OP_VERIFY && !p_match && p_tries == 2'h1
      |-> o_sw == 16'h63C0 && blk[p_sl])
    else $error("third wrong verify did not block");
  a_blocked_sw: assert property (o_rsp_valid && p_ok && p_op == PVC_OP_VERIFY
      && p_p1 == 8'h00 && p_len == `PVC_LEN_CODE && p_blk |-> o_sw == `PVC_SW_BLOCKED)
    else $error("verify on blocked code not 6983");
  // Every slot at once, so a block on any bank is caught, not just the first code
  a_blocked_deny: assert property ((blk & ~dis) != '0
      |=> (o_access_ok & $past(blk & ~dis)) == '0)
    else $error("blocked code granted access");
  a_retry_query: assert property (o_rsp_valid && p_ok && p_op == PVC_OP_VERIFY
      && p_p1 == 8'h00 && p_len == 8'h00 |-> o_sw == {12'h63C, 2'b00, p_tries}
      && tries[p_sl] == p_tries)
    else $error("empty verify did not report retries");
  a_change_store: assert property (p_good && p_op == PVC_OP_CHANGE
      && p_len == `PVC_LEN_CHANGE && p_match |-> code[p_sl] == p_new && tries[p_sl] == 2'h3)
    else $error("correct change did not store new code");
  a_disable_refuse: assert property (o_rsp_valid && p_ok && p_op == PVC_OP_DISABLE
      && p_len == `PVC_LEN_CODE && (p_blk || p_dis) |-> o_sw != `PVC_SW_OK)
    else $error("disable executed on disabled or blocked code");
  a_disable_done: assert property (p_good && p_op == PVC_OP_DISABLE
      && p_len == `PVC_LEN_CODE && p_match |-> dis[p_sl] && (alt_on[p_sl] || next_access[p_sl]))
    else $error("correct disable did not disable");
  a_alt_qual: assert property (o_rsp_valid && p_ok && p_op == PVC_OP_DISABLE && p_p1[7]
      && o_sw == `PVC_SW_OK |-> qual[p_asl] == `PVC_QUAL_USE)
    else $error("alternative key qualifier not set to use");

  c_verify_ok: cover property (p_good && p_op == PVC_OP_VERIFY && o_sw == `PVC_SW_OK);
  c_blocked: cover property (o_rsp_valid && o_sw == 16'h63C0 && blk[p_sl]);
  c_change_ok: cover property (p_good && p_op == PVC_OP_CHANGE && o_sw == `PVC_SW_OK);
  c_disable_alt: cover property (o_rsp_valid && p_ok && p_op == PVC_OP_DISABLE && p_p1[7]
      && o_sw == `PVC_SW_OK);
endmodule : pvc_core
`default_nettype wire

/* bench/pvc_term.sv */
// Terminal model that frames commands toward the code handler
`timescale 1ns/1ps
`default_nettype none
module pvc_term
  import pvc_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire pvc_op_type  i_op,
  input  wire logic [7:0]  i_p1,
  input  wire logic [7:0]  i_p2,
  input  wire logic [7:0]  i_len,
  input  wire logic [63:0] i_old,
  input  wire logic [63:0] i_new,
  output var  logic        o_valid = 1'b0,
  output var  pvc_op_type  o_op    = PVC_OP_VERIFY,
  output var  logic [7:0]  o_p1    = 8'h00,
  output var  logic [7:0]  o_p2    = 8'h00,
  output var  logic [7:0]  o_len   = 8'h00,
  output var  logic [63:0] o_old   = 64'h0,
  output var  logic [63:0] o_new   = 64'h0
);
  // Idle fields flip every cycle so a stale frame can never pass as a fresh one
  always @(posedge i_sys_clk) begin
    o_valid <= i_go;
    if (i_go) begin
      o_op  <= i_op;
      o_p1  <= i_p1;
      o_p2  <= i_p2;
      o_len <= i_len;
      o_old <= i_old;
      o_new <= i_new;
    end else begin
      o_op  <= pvc_op_type'(~o_op);
      o_p1  <= ~o_p1;
      o_p2  <= ~o_p2;
      o_len <= ~o_len;
      o_old <= ~o_old;
      o_new <= ~o_new;
    end
  end
endmodule : pvc_term
`default_nettype wire

/* bench/pin_verify_change_disable_tb.sv */
// Self-checking bench for the code handler against a queue-free state model
`timescale 1ns/1ps
`default_nettype none
module pin_verify_change_disable_tb;
  import pvc_pkg::*;
  localparam int          NK   = 4;
  localparam logic [63:0] INIT = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] NEWC = 64'h5A5A_0000_1234_FFFF;
  logic sys_clk = 1'b0, rstn = 1'b0, session_start = 1'b0, go = 1'b0, cmd_valid, rsp_valid;
  pvc_op_type op = PVC_OP_VERIFY, cmd_op;
  logic [7:0] p1 = '0, p2 = '0, len = '0, cmd_p1, cmd_p2, cmd_len, alt_mask = '0;
  logic [63:0] old_c = '0, new_c = '0, cmd_old, cmd_new;
  logic [15:0] sw;
  logic [2*NK-1:0] access_ok;
  logic [63:0] code [2*NK];
  int tries [2*NK];
  bit dis [2*NK], blk [2*NK], ver [2*NK];
  int error_cnt = 0, checked = 0, seed = 60;

  initial forever #2.5 sys_clk = ~sys_clk;

  pvc_term i_pvc_term (.i_sys_clk(sys_clk), .i_go(go), .i_op(op), .i_p1(p1), .i_p2(p2),
    .i_len(len), .i_old(old_c), .i_new(new_c), .o_valid(cmd_valid), .o_op(cmd_op),
    .o_p1(cmd_p1), .o_p2(cmd_p2), .o_len(cmd_len), .o_old(cmd_old), .o_new(cmd_new));
  pvc_core #(.NK(NK), .INIT_CODE(INIT)) i_pvc_core (.i_sys_clk(sys_clk), .i_rstn(rstn),
    .i_session_start(session_start), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_cmd_p1(cmd_p1), .i_cmd_p2(cmd_p2), .i_cmd_len(cmd_len), .i_old_code(cmd_old),
    .i_new_code(cmd_new), .o_rsp_valid(rsp_valid), .o_sw(sw), .o_access_ok(access_ok));

  // ----------------------------------------
  // Model, comparison and closing
  // ----------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] step();
    int s;
    logic [4:0] k;
    k = p2[4:0];
    s = (p2[7] ? NK : 0) + int'(k) - 1;
    if (p2[6:5] != 2'b00 || k == 5'h00 || k > NK) return 16'h6A88;
    if (op == PVC_OP_UNBLOCK) begin
      code[s] = new_c;
      tries[s] = 3;
      dis[s] = 0;
      blk[s] = 0;
      ver[s] = 1;
      return 16'h9000;
    end
    if (p1 != 8'h00 && !(op == PVC_OP_DISABLE && p1[7] && p1[6:5] == 2'b00 &&
        p1[4:0] != 5'h00 && p1[4:0] <= NK)) return 16'h6B00;
    if (op == PVC_OP_VERIFY && len == 8'h00) return {12'h63C, 4'(tries[s])};
    if (len != (op == PVC_OP_CHANGE ? 8'h10 : 8'h08)) return 16'h6700;
    if (blk[s]) return 16'h6983;
    if (dis[s]) return 16'h6984;
    if (old_c != code[s]) begin
      tries[s]--;
      ver[s] = 0;
      blk[s] = (tries[s] == 0);
      return {12'h63C, 4'(tries[s])};
    end
    tries[s] = 3;
    if (op == PVC_OP_CHANGE) code[s] = new_c;
    if (op == PVC_OP_DISABLE) dis[s] = 1;
    if (op == PVC_OP_VERIFY) ver[s] = 1;
    return 16'h9000;
  endfunction : step

  function automatic logic [15:0] acc_exp();
    logic [15:0] a;
    a = '0;
    for (int i = 0; i < 2 * NK; i++) a[i] = !blk[i] && (dis[i] || ver[i]);
    return a;
  endfunction : acc_exp

  // Same frame is repeated times cycles back to back; every answer is checked
  task automatic send(input pvc_op_type o, input logic [7:0] a, q, l,
                      input logic [63:0] c, n, input int times);
    int got;
    got = 0;
    @(posedge sys_clk);
    op <= o; p1 <= a; p2 <= q; len <= l; old_c <= c; new_c <= n; go <= 1'b1;
    for (int k = 1; k <= times + 3; k++) begin
      @(posedge sys_clk);
      if (k == times) go <= 1'b0;
      #1;
      if (rsp_valid === 1'b1) begin
        got++;
        chk(sw, step());
      end
    end
    chk(16'(got), 16'(times));
    if (got != times) give_verdict();
    chk({8'h00, access_ok & ~alt_mask}, acc_exp() & {8'h00, ~alt_mask});
  endtask : send

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] rv;
    for (int i = 0; i < 2 * NK; i++) begin
      code[i] = INIT; tries[i] = 3; dis[i] = 0; blk[i] = 0; ver[i] = 0;
    end
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 chk(sw, 16'h9000);
    chk({access_ok, 7'h00, rsp_valid}, 16'h0000);
    for (int i = 0; i < 8; i++) send(PVC_OP_VERIFY, 8'h00, {i[2], 2'b00, 5'(i % 4 + 1)},
      8'h00, '0, '0, 1);
    send(PVC_OP_VERIFY, 8'h00, 8'h01, 8'h08, INIT, '0, 1);
    send(PVC_OP_VERIFY, 8'h00, 8'h02, 8'h08, ~INIT, '0, 3);
    send(PVC_OP_VERIFY, 8'h00, 8'h02, 8'h08, INIT, '0, 1);
    send(PVC_OP_VERIFY, 8'h00, 8'h02, 8'h00, '0, '0, 1);
    send(PVC_OP_CHANGE, 8'h00, 8'h02, 8'h10, INIT, NEWC, 1);
    send(PVC_OP_DISABLE, 8'h00, 8'h02, 8'h08, INIT, '0, 1);
    @(posedge sys_clk) session_start <= 1'b1;
    @(posedge sys_clk) session_start <= 1'b0;
    for (int i = 0; i < 2 * NK; i++) ver[i] = 0;
    repeat (3) @(posedge sys_clk);
    #1 chk({8'h00, access_ok}, acc_exp());
    send(PVC_OP_UNBLOCK, 8'h00, 8'h02, 8'h10, '0, NEWC, 1);
    send(PVC_OP_VERIFY, 8'h00, 8'h02, 8'h08, NEWC, '0, 1);
    send(PVC_OP_CHANGE, 8'h00, 8'h03, 8'h10, ~INIT, NEWC, 2);
    send(PVC_OP_CHANGE, 8'h00, 8'h03, 8'h10, INIT, NEWC, 1);
    send(PVC_OP_VERIFY, 8'h00, 8'h03, 8'h08, NEWC, '0, 1);
    send(PVC_OP_DISABLE, 8'h00, 8'h04, 8'h08, ~INIT, '0, 3);
    send(PVC_OP_DISABLE, 8'h00, 8'h81, 8'h08, INIT, '0, 2);
    send(PVC_OP_VERIFY, 8'h00, 8'h81, 8'h08, INIT, '0, 1);
    send(PVC_OP_VERIFY, 8'h00, 8'h81, 8'h00, '0, '0, 1);
    send(PVC_OP_CHANGE, 8'h00, 8'h81, 8'h10, INIT, NEWC, 1);
    // Slot guarded by a replacement key has no fixed grant to compare against
    alt_mask = 8'h20;
    send(PVC_OP_DISABLE, 8'h81, 8'h82, 8'h08, INIT, '0, 1);
    chk({15'h0000, access_ok[5]}, 16'h0000);
    send(PVC_OP_VERIFY, 8'h00, 8'h01, 8'h08, INIT, '0, 1);
    chk({15'h0000, access_ok[5]}, 16'h0001);
    send(PVC_OP_DISABLE, 8'h85, 8'h83, 8'h08, INIT, '0, 1);
    foreach (p1[i]) if (i < 4) send(PVC_OP_VERIFY, 8'h00, i[1] ? (i[0] ? 8'h41 : 8'h21)
      : (i[0] ? 8'h05 : 8'h00), 8'h08, INIT, '0, 1);
    send(PVC_OP_VERIFY, 8'h01, 8'h83, 8'h08, INIT, '0, 1);
    send(PVC_OP_CHANGE, 8'h00, 8'h83, 8'h08, INIT, NEWC, 1);
    for (int r = 0; r < 24; r++) begin
      rv = $random(seed);
      send(pvc_op_type'(rv[5:4]), 8'h00, {rv[3], 2'b00, 5'(rv[1:0]) + 5'h01},
        rv[4] ? 8'h10 : 8'h08, rv[6] ? code[{rv[3], rv[1:0]}] : {$random(seed), rv},
        {$random(seed), $random(seed)}, 1);
    end
    give_verdict();
  end
endmodule : pin_verify_change_disable_tb
`default_nettype wire
